// [pkg/ugcc_defines.vh]
`ifndef UGCC_DEFINES_VH
`define UGCC_DEFINES_VH

// ----------------------------------------
// register indexes within a channel block
// ----------------------------------------
`define UGCC_IDX_CFG0 4'h0
`define UGCC_IDX_CFG1 4'h1
`define UGCC_IDX_MPS_H 4'h2
`define UGCC_IDX_MPS_L 4'h3
`define UGCC_IDX_HUB 4'h4
`define UGCC_IDX_PORT 4'h5
`define UGCC_IDX_FUNC 4'h6
`define UGCC_IDX_EP 4'h7
`define UGCC_IDX_CNT_HH 4'h8
`define UGCC_IDX_CNT_HL 4'h9
`define UGCC_IDX_CNT_LH 4'hA
`define UGCC_IDX_CNT_LL 4'hB
`define UGCC_IDX_INTV_H 4'hC
`define UGCC_IDX_INTV_L 4'hD
`define UGCC_IDX_AREA 4'hE
`define UGCC_IDX_STAT 4'hF

// ----------------------------------------
// field positions
// ----------------------------------------
`define UGCC_F_SPEED 7:6
`define UGCC_B_TOGGLE 4
`define UGCC_B_DONE 1
`define UGCC_B_EXEC 0
`define UGCC_B_DIR 7
`define UGCC_F_CLASS 5:4
`define UGCC_B_ASSIST 0

// ----------------------------------------
// encodings and reset values
// ----------------------------------------
`define UGCC_SPEED_HS 2'h0
`define UGCC_CLASS_BULK 2'h0
`define UGCC_CLASS_ISO 2'h2
`define UGCC_MPS_RESET 11'h040
`define UGCC_MPS_MIN 11'h001
`define UGCC_MPS_MAX 11'h400
`define UGCC_CBW_LEN 11'h01F
`define UGCC_CSW_LEN 11'h00D
`define UGCC_BOT_CHAN 3'h0
`define UGCC_PH_IDLE 2'h0
`define UGCC_PH_CMD 2'h1
`define UGCC_PH_DATA 2'h2
`define UGCC_PH_STAT 2'h3

`endif

// [rtl/ugcc_rr_arb.v]
`timescale 1ns/100ps
`include "ugcc_defines.vh"

// round robin pick among requesting channels
module ugcc_rr_arb #(
	parameter NCH = 5
) (
	input wire clk,
	input wire rst_n,
	input wire [NCH-1:0] req,
	input wire take,
	output reg [2:0] grant,
	output reg grant_valid
);

	reg [2:0] ptr_reg;
	integer i;
	reg [2:0] k;

	// first requester at or after the pointer
	always @*
	begin
		grant = 3'h0;
		grant_valid = 1'b0;
		k = 3'h0;
		for (i = NCH - 1; i >= 0; i = i - 1)
		begin
			k = ptr_reg + i[2:0];
			if (k >= NCH[2:0])
				k = k - NCH[2:0];
			if (req[k])
			begin
				grant = k;
				grant_valid = 1'b1;
			end
		end
	end

	// pointer moves past the channel just served
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			ptr_reg <= 3'h0;
		else if (take)
			ptr_reg <= (grant == NCH[2:0] - 3'h1) ? 3'h0 : grant + 3'h1;
	end

endmodule

// [rtl/ugcc_bot_seq.v]
`timescale 1ns/100ps
`include "ugcc_defines.vh"

// command, data and status phase walker for the mass-storage assist
module ugcc_bot_seq (
	input wire clk,
	input wire rst_n,
	input wire start,
	input wire phase_done,
	input wire has_data,
	output reg [1:0] phase_reg
);

	reg [1:0] phase_next;

	// next phase
	always @*
	begin
		phase_next = phase_reg;
		if (start)
			phase_next = `UGCC_PH_CMD;
		else if (phase_done)
		begin
			case (phase_reg)
				`UGCC_PH_CMD: phase_next = has_data ? `UGCC_PH_DATA : `UGCC_PH_STAT;
				`UGCC_PH_DATA: phase_next = `UGCC_PH_STAT;
				`UGCC_PH_STAT: phase_next = `UGCC_PH_IDLE;
				default: phase_next = `UGCC_PH_IDLE;
			endcase
		end
	end

	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			phase_reg <= `UGCC_PH_IDLE;
		else
			phase_reg <= phase_next;
	end

endmodule

// [rtl/ugcc_top.v]
// How it works
// - five general channels, one endpoint each
// - per-channel speed used for its transactions
// - toggle write seeds; read shows live toggle
// - per-channel IN or OUT direction
// - class selector only on four multi-purpose channels
// - max packet 1 to 1024, two bytes
// - hub address and port for splits
// - function address and endpoint as destination
// - four-byte total byte count per request
// - token period on four multi-purpose channels
// - bulk-only channel sequences command, data, status
// - hardware schedules transactions by itself
// - only channels with execute set are scheduled
// - one transaction per pick, then pick again
`timescale 1ns/100ps
`include "ugcc_defines.vh"

module ugcc_top #(
	parameter NCH = 5
) (
	input wire clk,
	input wire rst_n,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [7:0] reg_rdata_reg,
	input wire frame_tick,
	output reg txn_start_reg,
	output reg [2:0] txn_chan_reg,
	output reg [1:0] txn_speed_reg,
	output reg txn_dir_reg,
	output reg [1:0] txn_class_reg,
	output reg txn_toggle_reg,
	output reg [6:0] txn_func_reg,
	output reg [3:0] txn_ep_reg,
	output reg txn_split_reg,
	output reg [6:0] txn_hub_reg,
	output reg [6:0] txn_port_reg,
	output reg [10:0] txn_len_reg,
	output reg [2:0] txn_area_reg,
	input wire txn_done,
	input wire txn_ack,
	input wire [10:0] txn_count,
	output reg [NCH-1:0] chan_active_reg
);

	localparam ST_IDLE = 1'b0;
	localparam ST_WAIT = 1'b1;

	// ----------------------------------------
	// helpers
	// ----------------------------------------

	// legal max packet length from the raw field
	function [10:0] ugcc_mps;
		input [10:0] raw;
		begin
			if (raw == 11'h000)
				ugcc_mps = `UGCC_MPS_MIN;
			else if (raw > `UGCC_MPS_MAX)
				ugcc_mps = `UGCC_MPS_MAX;
			else
				ugcc_mps = raw;
		end
	endfunction

	// packet length limited by bytes still owed
	function [10:0] ugcc_clip;
		input [31:0] rem;
		input [10:0] mps;
		begin
			if (rem < {21'h000000, mps})
				ugcc_clip = rem[10:0];
			else
				ugcc_clip = mps;
		end
	endfunction

	// ----------------------------------------
	// channel settings and state
	// ----------------------------------------
	reg [1:0] speed_reg [0:NCH-1];
	reg dir_reg [0:NCH-1];
	reg [1:0] class_reg [0:NCH-1];
	reg [10:0] mps_reg [0:NCH-1];
	reg [6:0] hub_reg [0:NCH-1];
	reg [6:0] port_reg [0:NCH-1];
	reg [6:0] func_reg [0:NCH-1];
	reg [3:0] ep_reg [0:NCH-1];
	reg [31:0] total_reg [0:NCH-1];
	reg [31:0] remain_reg [0:NCH-1];
	reg [15:0] intv_reg [0:NCH-1];
	reg [15:0] wait_reg [0:NCH-1];
	reg [2:0] area_reg [0:NCH-1];
	reg [NCH-1:0] exec_reg;
	reg [NCH-1:0] done_reg;
	reg [NCH-1:0] toggle_reg;
	reg assist_reg;

	reg state_reg;
	reg [2:0] cur_reg;
	reg ctl_phase_reg;
	wire [1:0] phase;
	wire [2:0] grant;
	wire grant_valid;
	reg [NCH-1:0] req;
	integer i;
	integer j;

	wire [2:0] wch = reg_addr[6:4];
	wire [3:0] widx = reg_addr[3:0];
	wire hit = !reg_addr[7] && (wch < NCH[2:0]);
	wire wr_hit = reg_wr && hit;
	wire arm = wr_hit && (widx == `UGCC_IDX_CFG0) && reg_wdata[`UGCC_B_EXEC];
	wire bot_start = arm && (wch == `UGCC_BOT_CHAN) && assist_reg;

	// ----------------------------------------
	// completion decode for the channel in flight
	// ----------------------------------------
	wire cur_iso = (class_reg[cur_reg] == `UGCC_CLASS_ISO);
	wire cur_bulk = (class_reg[cur_reg] == `UGCC_CLASS_BULK);
	wire cur_assist = assist_reg && (cur_reg == `UGCC_BOT_CHAN);
	wire fin_evt = (state_reg == ST_WAIT) && txn_done;
	wire adv_evt = fin_evt && (txn_ack || cur_iso);
	wire [31:0] cur_rem = remain_reg[cur_reg];
	wire data_last = ({21'h000000, txn_count} >= cur_rem) || (txn_count < txn_len_reg);
	wire ph_done = adv_evt && cur_assist && (ctl_phase_reg || data_last);
	wire xfer_end = adv_evt && (cur_assist ? (ctl_phase_reg && phase == `UGCC_PH_STAT)
		: data_last);

	// ----------------------------------------
	// scheduling request vector
	// ----------------------------------------

	always @*
	begin
		req = {NCH{1'b0}};
		for (j = 0; j < NCH; j = j + 1)
			req[j] = exec_reg[j] && (class_reg[j] == `UGCC_CLASS_BULK || wait_reg[j] == 16'h0000);
	end

	ugcc_rr_arb #(
		.NCH(NCH)
	) u_arb (
		.clk(clk),
		.rst_n(rst_n),
		.req(req),
		.take(state_reg == ST_IDLE && grant_valid),
		.grant(grant),
		.grant_valid(grant_valid)
	);

	ugcc_bot_seq u_bot (
		.clk(clk),
		.rst_n(rst_n),
		.start(bot_start),
		.phase_done(ph_done),
		.has_data(remain_reg[`UGCC_BOT_CHAN] != 32'h0),
		.phase_reg(phase)
	);

	// ----------------------------------------
	// channel registers: hardware then software
	// ----------------------------------------
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			for (i = 0; i < NCH; i = i + 1)
			begin
				speed_reg[i] <= `UGCC_SPEED_HS;
				dir_reg[i] <= 1'b0;
				class_reg[i] <= `UGCC_CLASS_BULK;
				mps_reg[i] <= `UGCC_MPS_RESET;
				hub_reg[i] <= 7'h00;
				port_reg[i] <= 7'h00;
				func_reg[i] <= 7'h00;
				ep_reg[i] <= 4'h0;
				total_reg[i] <= 32'h0;
				remain_reg[i] <= 32'h0;
				intv_reg[i] <= 16'h0000;
				wait_reg[i] <= 16'h0000;
				area_reg[i] <= 3'h0;
			end
			exec_reg <= {NCH{1'b0}};
			done_reg <= {NCH{1'b0}};
			toggle_reg <= {NCH{1'b0}};
			assist_reg <= 1'b0;
		end
		else
		begin
			if (frame_tick)
				for (i = 0; i < NCH; i = i + 1)
					if (wait_reg[i] != 16'h0000)
						wait_reg[i] <= wait_reg[i] - 16'h0001;
			if (fin_evt && !cur_bulk)
				wait_reg[cur_reg] <= intv_reg[cur_reg];
			if (adv_evt && !cur_iso)
				toggle_reg[cur_reg] <= ~toggle_reg[cur_reg];
			// bytes owed shrink by bytes moved
			if (adv_evt && !ctl_phase_reg)
				remain_reg[cur_reg] <= ({21'h000000, txn_count} >= cur_rem) ? 32'h0
					: cur_rem - {21'h000000, txn_count};
			if (xfer_end)
				exec_reg[cur_reg] <= 1'b0;
			// software writes, a new arm wins over the clear
			if (wr_hit)
			begin
				if (widx == `UGCC_IDX_CFG0)
				begin
					speed_reg[wch] <= reg_wdata[`UGCC_F_SPEED];
					toggle_reg[wch] <= reg_wdata[`UGCC_B_TOGGLE];
					exec_reg[wch] <= reg_wdata[`UGCC_B_EXEC];
					if (arm)
					begin
						remain_reg[wch] <= total_reg[wch];
						done_reg[wch] <= 1'b0;
						wait_reg[wch] <= 16'h0000;
					end
				end
				else if (widx == `UGCC_IDX_CFG1)
				begin
					dir_reg[wch] <= reg_wdata[`UGCC_B_DIR];
					if (wch != `UGCC_BOT_CHAN)
						class_reg[wch] <= reg_wdata[`UGCC_F_CLASS];
					else
						assist_reg <= reg_wdata[`UGCC_B_ASSIST];
				end
				else if (widx == `UGCC_IDX_MPS_H)
					mps_reg[wch][10:8] <= reg_wdata[2:0];
				else if (widx == `UGCC_IDX_MPS_L)
					mps_reg[wch][7:0] <= reg_wdata;
				else if (widx == `UGCC_IDX_HUB)
					hub_reg[wch] <= reg_wdata[6:0];
				else if (widx == `UGCC_IDX_PORT)
					port_reg[wch] <= reg_wdata[6:0];
				else if (widx == `UGCC_IDX_FUNC)
					func_reg[wch] <= reg_wdata[6:0];
				else if (widx == `UGCC_IDX_EP)
					ep_reg[wch] <= reg_wdata[3:0];
				else if (widx == `UGCC_IDX_CNT_HH)
					total_reg[wch][31:24] <= reg_wdata;
				else if (widx == `UGCC_IDX_CNT_HL)
					total_reg[wch][23:16] <= reg_wdata;
				else if (widx == `UGCC_IDX_CNT_LH)
					total_reg[wch][15:8] <= reg_wdata;
				else if (widx == `UGCC_IDX_CNT_LL)
					total_reg[wch][7:0] <= reg_wdata;
				else if (widx == `UGCC_IDX_INTV_H && wch != `UGCC_BOT_CHAN)
					intv_reg[wch][15:8] <= reg_wdata;
				else if (widx == `UGCC_IDX_INTV_L && wch != `UGCC_BOT_CHAN)
					intv_reg[wch][7:0] <= reg_wdata;
				else if (widx == `UGCC_IDX_AREA)
					area_reg[wch] <= reg_wdata[2:0];
			end
			// finish flag, set wins over the arm clear
			if (xfer_end)
				done_reg[cur_reg] <= 1'b1;
		end
	end

	// ----------------------------------------
	// transaction engine
	// ----------------------------------------

	// issue on its own, wait for result
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_reg <= ST_IDLE;
			cur_reg <= 3'h0;
			ctl_phase_reg <= 1'b0;
			txn_start_reg <= 1'b0;
			txn_chan_reg <= 3'h0;
			txn_speed_reg <= `UGCC_SPEED_HS;
			txn_dir_reg <= 1'b0;
			txn_class_reg <= `UGCC_CLASS_BULK;
			txn_toggle_reg <= 1'b0;
			txn_func_reg <= 7'h00;
			txn_ep_reg <= 4'h0;
			txn_split_reg <= 1'b0;
			txn_hub_reg <= 7'h00;
			txn_port_reg <= 7'h00;
			txn_len_reg <= 11'h000;
			txn_area_reg <= 3'h0;
		end
		else
		begin
			txn_start_reg <= 1'b0;
			case (state_reg)
				ST_IDLE:
				begin
					if (grant_valid)
					begin
						state_reg <= ST_WAIT;
						cur_reg <= grant;
						txn_start_reg <= 1'b1;
						txn_chan_reg <= grant;
						txn_speed_reg <= speed_reg[grant];
						txn_split_reg <= (speed_reg[grant] != `UGCC_SPEED_HS);
						txn_class_reg <= class_reg[grant];
						txn_toggle_reg <= toggle_reg[grant];
						txn_func_reg <= func_reg[grant];
						txn_ep_reg <= ep_reg[grant];
						txn_hub_reg <= hub_reg[grant];
						txn_port_reg <= port_reg[grant];
						txn_area_reg <= area_reg[grant];
						if (assist_reg && grant == `UGCC_BOT_CHAN && phase == `UGCC_PH_CMD)
						begin
							ctl_phase_reg <= 1'b1;
							txn_dir_reg <= 1'b0;
							txn_len_reg <= `UGCC_CBW_LEN;
						end
						else if (assist_reg && grant == `UGCC_BOT_CHAN
							&& phase == `UGCC_PH_STAT)
						begin
							ctl_phase_reg <= 1'b1;
							txn_dir_reg <= 1'b1;
							txn_len_reg <= `UGCC_CSW_LEN;
						end
						else
						begin
							ctl_phase_reg <= 1'b0;
							txn_dir_reg <= dir_reg[grant];
							txn_len_reg <= ugcc_clip(remain_reg[grant], ugcc_mps(mps_reg[grant]));
						end
					end
				end
				ST_WAIT:
				begin
					if (txn_done)
						state_reg <= ST_IDLE;
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// register read and status outputs
	// ----------------------------------------

	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			reg_rdata_reg <= 8'h00;
			chan_active_reg <= {NCH{1'b0}};
		end
		else
		begin
			chan_active_reg <= exec_reg;
			reg_rdata_reg <= 8'h00;
			if (reg_rd && hit)
			begin
				if (widx == `UGCC_IDX_CFG0)
					reg_rdata_reg <= {speed_reg[wch], 1'b0, toggle_reg[wch], 2'h0,
						done_reg[wch], exec_reg[wch]};
				else if (widx == `UGCC_IDX_CFG1)
					reg_rdata_reg <= {dir_reg[wch], 1'b0, class_reg[wch], 3'h0,
						(wch == `UGCC_BOT_CHAN) && assist_reg};
				else if (widx == `UGCC_IDX_MPS_H)
					reg_rdata_reg <= {5'h00, mps_reg[wch][10:8]};
				else if (widx == `UGCC_IDX_MPS_L)
					reg_rdata_reg <= mps_reg[wch][7:0];
				else if (widx == `UGCC_IDX_HUB)
					reg_rdata_reg <= {1'b0, hub_reg[wch]};
				else if (widx == `UGCC_IDX_PORT)
					reg_rdata_reg <= {1'b0, port_reg[wch]};
				else if (widx == `UGCC_IDX_FUNC)
					reg_rdata_reg <= {1'b0, func_reg[wch]};
				else if (widx == `UGCC_IDX_EP)
					reg_rdata_reg <= {4'h0, ep_reg[wch]};
				else if (widx == `UGCC_IDX_CNT_HH)
					reg_rdata_reg <= total_reg[wch][31:24];
				else if (widx == `UGCC_IDX_CNT_HL)
					reg_rdata_reg <= total_reg[wch][23:16];
				else if (widx == `UGCC_IDX_CNT_LH)
					reg_rdata_reg <= total_reg[wch][15:8];
				else if (widx == `UGCC_IDX_CNT_LL)
					reg_rdata_reg <= total_reg[wch][7:0];
				else if (widx == `UGCC_IDX_INTV_H)
					reg_rdata_reg <= intv_reg[wch][15:8];
				else if (widx == `UGCC_IDX_INTV_L)
					reg_rdata_reg <= intv_reg[wch][7:0];
				else if (widx == `UGCC_IDX_AREA)
					reg_rdata_reg <= {5'h00, area_reg[wch]};
				else
					reg_rdata_reg <= {6'h00, (wch == `UGCC_BOT_CHAN) ? phase : 2'h0};
			end
		end
	end

endmodule

// [verif/ugcc_checker.sv]
`timescale 1ns/100ps
`include "ugcc_defines.vh"

// ----------------------------------------
// link and register port checks
// ----------------------------------------
module ugcc_checker #(
	parameter NCH = 5
) (
	input logic clk,
	input logic rst_n,
	input logic reg_rd,
	input logic [7:0] reg_rdata_reg,
	input logic txn_start_reg,
	input logic [2:0] txn_chan_reg,
	input logic [1:0] txn_speed_reg,
	input logic [1:0] txn_class_reg,
	input logic [6:0] txn_func_reg,
	input logic txn_split_reg,
	input logic [10:0] txn_len_reg,
	input logic txn_done,
	input logic [NCH-1:0] chan_active_reg
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	logic busy_reg;
	// transaction in flight between start and done
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			busy_reg <= 1'b0;
		else if (txn_start_reg)
			busy_reg <= 1'b1;
		else if (txn_done)
			busy_reg <= 1'b0;
	end
	sequence s_done;
		busy_reg && txn_done;
	endsequence
	sequence s_quiet;
		!txn_start_reg;
	endsequence
	AST_RD_IDLE: assert property (!$past(reg_rd) |-> reg_rdata_reg == 8'h00)
		else $error("read data outside the read answer cycle");
	AST_ONE_TXN: assert property (busy_reg |-> s_quiet)
		else $error("start while a transaction is in flight");
	AST_GAP: assert property (s_done |=> s_quiet)
		else $error("start right after the done cycle");
	AST_EXEC_GATE: assert property (txn_start_reg |-> chan_active_reg[txn_chan_reg])
		else $error("start on a channel that is not armed");
	AST_SPLIT: assert property (txn_start_reg |-> txn_split_reg == (txn_speed_reg != 2'h0))
		else $error("split flag does not follow speed");
	AST_LEN: assert property (txn_start_reg |-> txn_len_reg >= `UGCC_MPS_MIN
		&& txn_len_reg <= `UGCC_MPS_MAX)
		else $error("transaction length out of range");
	AST_STAND: assert property (!txn_start_reg |-> $stable(txn_chan_reg) && $stable(txn_len_reg)
		&& $stable(txn_func_reg))
		else $error("transaction fields moved between starts");
	AST_CH0_BULK: assert property (txn_start_reg && txn_chan_reg == 3'h0
		|-> txn_class_reg == `UGCC_CLASS_BULK)
		else $error("bulk-only channel issued another class");
	AST_CHAN_RANGE: assert property (txn_start_reg |-> txn_chan_reg < NCH)
		else $error("transaction on a channel that does not exist");
endmodule

// [verif/ugcc_link_model.sv]
`timescale 1ns/100ps

// ----------------------------------------
// downstream function answering transactions
// ----------------------------------------
module ugcc_link_model (
	input logic clk,
	input logic rst_n,
	input logic txn_start_reg,
	input logic [10:0] txn_len_reg,
	input logic nak_next,
	input logic short_next,
	output logic txn_done,
	output logic txn_ack,
	output logic [10:0] txn_count
);
	logic busy_reg;
	logic slow_reg;
	logic [2:0] wait_reg;
	// one answer each
	// prompt and slow answers alternate; idle result lines scramble
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			busy_reg <= 1'b0;
			slow_reg <= 1'b0;
			wait_reg <= 3'h0;
			txn_done <= 1'b0;
			txn_ack <= 1'b0;
			txn_count <= 11'h000;
		end
		else
		begin
			txn_done <= 1'b0;
			txn_ack <= ~txn_ack;
			txn_count <= ~txn_count;
			if (txn_start_reg)
			begin
				busy_reg <= 1'b1;
				wait_reg <= slow_reg ? 3'h6 : 3'h1;
				slow_reg <= ~slow_reg;
			end
			else if (busy_reg && wait_reg != 3'h0)
				wait_reg <= wait_reg - 3'h1;
			else if (busy_reg)
			begin
				busy_reg <= 1'b0;
				txn_done <= 1'b1;
				txn_ack <= ~nak_next;
				txn_count <= short_next ? txn_len_reg - 11'h001 : txn_len_reg;
			end
		end
	end
endmodule

// [verif/ugcc_top_tb.sv]
`timescale 1ns/100ps
`include "ugcc_defines.vh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_fail++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end

// ----------------------------------------
// channel configuration bench
// ----------------------------------------
module ugcc_top_tb;
	localparam int NCH = 5;
	logic clk, rst_n, reg_wr, reg_rd, frame_tick, nak_next, short_next, rd_q;
	logic [7:0] reg_addr, reg_wdata, reg_rdata_reg;
	logic txn_start_reg, txn_dir_reg, txn_toggle_reg, txn_split_reg, txn_done, txn_ack;
	logic [2:0] txn_chan_reg, txn_area_reg;
	logic [1:0] txn_speed_reg, txn_class_reg;
	logic [6:0] txn_func_reg, txn_hub_reg, txn_port_reg;
	logic [3:0] txn_ep_reg;
	logic [10:0] txn_len_reg, txn_count;
	logic [NCH-1:0] chan_active_reg;
	logic [7:0] rq[$];
	logic [48:0] tq[$];
	integer seed = 93;
	int n_fail = 0;
	int samples_checked = 0;

	ugcc_top #(.NCH(NCH)) i_dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_reg(reg_rdata_reg),
		.frame_tick(frame_tick), .txn_start_reg(txn_start_reg), .txn_chan_reg(txn_chan_reg),
		.txn_speed_reg(txn_speed_reg), .txn_dir_reg(txn_dir_reg), .txn_class_reg(txn_class_reg),
		.txn_toggle_reg(txn_toggle_reg), .txn_func_reg(txn_func_reg), .txn_ep_reg(txn_ep_reg),
		.txn_split_reg(txn_split_reg), .txn_hub_reg(txn_hub_reg), .txn_port_reg(txn_port_reg),
		.txn_len_reg(txn_len_reg), .txn_area_reg(txn_area_reg), .txn_done(txn_done),
		.txn_ack(txn_ack), .txn_count(txn_count), .chan_active_reg(chan_active_reg));
	ugcc_link_model i_link (.clk(clk), .rst_n(rst_n), .txn_start_reg(txn_start_reg),
		.txn_len_reg(txn_len_reg), .nak_next(nak_next), .short_next(short_next),
		.txn_done(txn_done), .txn_ack(txn_ack), .txn_count(txn_count));

	// 50 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// verdict and end of run
	task automatic test_done;
		$display("mismatches %0d comparisons %0d", n_fail, samples_checked);
		if (n_fail == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// one-cycle register write and read
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		rq.push_back(e);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
	endtask

	// note of one expected transaction
	task automatic ex(input logic [2:0] c, input logic [1:0] s, input logic d,
		input logic [1:0] cl, input logic t, input logic [6:0] f, input logic [3:0] ep,
		input logic [6:0] h, input logic [6:0] p, input logic [10:0] l, input logic [2:0] ar);
		tq.push_back({c, s, d, cl, t, f, ep, s != `UGCC_SPEED_HS, h, p, l, ar});
	endtask

	// writes register indexes 1 to E of a channel
	task automatic setup(input logic [2:0] c, input logic [7:0] cfg1, input logic [10:0] mps,
		input logic [6:0] h, input logic [6:0] p, input logic [6:0] f, input logic [3:0] ep,
		input logic [31:0] n, input logic [2:0] ar);
		logic [7:0] v [1:14];
		v = '{cfg1, {5'h00, mps[10:8]}, mps[7:0], {1'b0, h}, {1'b0, p}, {1'b0, f},
			{4'h0, ep}, n[31:24], n[23:16], n[15:8], n[7:0], 8'h00, 8'h00, {5'h00, ar}};
		for (int i = 1; i < 15; i++)
			wr({1'b0, c, 4'(i)}, v[i]);
	endtask

	// bounded wait until all channels stop
	task automatic wait_idle;
		int n;
		n = 0;
		while ((tq.size() != 0 || chan_active_reg !== '0) && n < 3000)
		begin
			@(posedge clk);
			n++;
		end
		if (n >= 3000)
		begin
			n_fail++;
			test_done();
		end
		repeat (4) @(posedge clk);
	endtask

	// result watcher and random frame pulses
	always @(posedge clk)
	begin
		rd_q <= reg_rd;
		frame_tick <= ($random(seed) % 16) == 0;
		if (rd_q === 1'b1) `CHK(reg_rdata_reg, rq.pop_front())
		if (txn_start_reg === 1'b1) `CHK({txn_chan_reg, txn_speed_reg, txn_dir_reg,
			txn_class_reg, txn_toggle_reg, txn_func_reg, txn_ep_reg, txn_split_reg,
			txn_hub_reg, txn_port_reg, txn_len_reg, txn_area_reg}, tq.pop_front())
		if (txn_done === 1'b1)
		begin
			nak_next <= 1'b0;
			short_next <= 1'b0;
		end
	end

	// main sequence
	initial
	begin
		logic [6:0] f;
		logic [10:0] el;
		rst_n = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		frame_tick = 1'b0;
		nak_next = 1'b0;
		short_next = 1'b0;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		for (int c = 0; c < 8; c++)
			rd({1'b0, 3'(c), 4'h3}, c < NCH ? 8'h40 : 8'h00);
		rd(8'h00, 8'h00);
		wr(8'h01, 8'h20);
		rd(8'h01, 8'h00);
		wr(8'h31, 8'hA0);
		rd(8'h31, 8'hA0);
		wr(8'h0C, 8'hFF);
		rd(8'h0C, 8'h00);
		wr(8'h4D, 8'hA5);
		rd(8'h4D, 8'hA5);
		wr(8'hC7, 8'hFF);
		rd(8'hC7, 8'h00);
		rd(8'h47, 8'h00);
		// full speed out through a hub, first try refused
		setup(3'h1, 8'h00, 11'h008, 7'h05, 7'h02, 7'h12, 4'h3, 32'h10, 3'h2);
		ex(3'h1, 2'h1, 1'b0, 2'h0, 1'b0, 7'h12, 4'h3, 7'h05, 7'h02, 11'h008, 3'h2);
		ex(3'h1, 2'h1, 1'b0, 2'h0, 1'b0, 7'h12, 4'h3, 7'h05, 7'h02, 11'h008, 3'h2);
		ex(3'h1, 2'h1, 1'b0, 2'h0, 1'b1, 7'h12, 4'h3, 7'h05, 7'h02, 11'h008, 3'h2);
		nak_next <= 1'b1;
		wr(8'h10, 8'h41);
		wait_idle();
		rd(8'h10, 8'h42);
		// same channel re-aimed, toggle seeded high
		wr(8'h16, 8'h21);
		wr(8'h1B, 8'h08);
		ex(3'h1, 2'h1, 1'b0, 2'h0, 1'b1, 7'h21, 4'h3, 7'h05, 7'h02, 11'h008, 3'h2);
		wr(8'h10, 8'h51);
		wait_idle();
		rd(8'h10, 8'h42);
		// in channel: packet limits and speeds 0 to 2
		for (int i = 0; i < 3; i++)
		begin
			f = 7'($random(seed));
			el = i == 0 ? `UGCC_MPS_MIN : (i == 1 ? `UGCC_MPS_MAX : 11'h3FF);
			setup(3'h2, 8'h80, i == 0 ? 11'h000 : (i == 1 ? 11'h401 : 11'h3FF), 7'h00, 7'h00,
				f, 4'h1, {21'h0, el}, 3'h3);
			ex(3'h2, 2'(i), 1'b1, 2'h0, 1'b0, f, 4'h1, 7'h00, 7'h00, el, 3'h3);
			wr(8'h20, {2'(i), 6'h01});
			wait_idle();
			rd(8'h20, {2'(i), 6'h12});
		end
		// short packet ends the transfer
		setup(3'h2, 8'h80, 11'h010, 7'h00, 7'h00, 7'h44, 4'h2, 32'h20, 3'h3);
		ex(3'h2, 2'h0, 1'b1, 2'h0, 1'b0, 7'h44, 4'h2, 7'h00, 7'h00, 11'h010, 3'h3);
		short_next <= 1'b1;
		wr(8'h20, 8'h01);
		wait_idle();
		rd(8'h20, 8'h12);
		// mass-storage assist: command, data, status
		setup(`UGCC_BOT_CHAN, 8'h81, 11'h040, 7'h00, 7'h00, 7'h33, 4'h1, 32'h4, 3'h1);
		ex(3'h0, 2'h0, 1'b0, 2'h0, 1'b0, 7'h33, 4'h1, 7'h00, 7'h00, `UGCC_CBW_LEN, 3'h1);
		ex(3'h0, 2'h0, 1'b1, 2'h0, 1'b1, 7'h33, 4'h1, 7'h00, 7'h00, 11'h004, 3'h1);
		ex(3'h0, 2'h0, 1'b1, 2'h0, 1'b0, 7'h33, 4'h1, 7'h00, 7'h00, `UGCC_CSW_LEN, 3'h1);
		wr(8'h00, 8'h01);
		wait_idle();
		rd(8'h00, 8'h12);
		rd(8'h0F, 8'h00);
		repeat (4) @(posedge clk);
		test_done();
	end
endmodule

bind ugcc_top ugcc_checker #(.NCH(NCH)) i_chk (.clk(clk), .rst_n(rst_n), .reg_rd(reg_rd),
	.reg_rdata_reg(reg_rdata_reg), .txn_start_reg(txn_start_reg), .txn_chan_reg(txn_chan_reg),
	.txn_speed_reg(txn_speed_reg), .txn_class_reg(txn_class_reg), .txn_func_reg(txn_func_reg),
	.txn_split_reg(txn_split_reg), .txn_len_reg(txn_len_reg), .txn_done(txn_done),
	.chan_active_reg(chan_active_reg));
